// *** shared/codec_cfg.svh ***
// Register map, field positions, reset values and word lengths of the voice codec serial block.
// Included by the voice_codec_serial module only; holds definitions only.
//
// Functional notes
// - A companded word is 8 bits, all sample bits, sign bit first.
// - A linear word is 16 bits: 13 sample bits sign first, then 3 attenuation bits on receive, zeros on transmit.
// - The linear sample is a 13-bit two's-complement value, the same for both companding variants.
// - Each encoded transmit sample is held and sent in the first 8 or 16 data clocks of the second frame after it is encoded.
// - A companded receive word is taken on the first eight clocks in fixed rate, the last eight in variable rate.
// - A linear receive word is taken on the first 16 data clocks of the frame and then handed to the decoder.
// - The attenuation field is read MSB first; 000 is full volume and each step adds 3 dB up to 21 dB at 111.
// - Attenuation is applied per word and never applied to later words, so every linear receive word must carry it.
// - While the silence input is asserted the transmit line carries an all-zero code.
// - In companded mode a level near the noise floor sends zero bits, released with hysteresis.
// - One companding law, mu-law or A-law, is fixed by the product variant.
// - DC offset is cancelled by long-term averaging of the encoder sign bit, subtracted at the encoder input.
// - Attenuation and control bits always follow the sample bits within a word.
// - In fixed rate, transmit bits leave on rising clock edges after the frame sync rises; receive bits are sampled on falling edges.
// - In variable rate, transmit bits leave on rising edges while the sync is high, and the word repeats while it stays high.
`ifndef CODEC_CFG_SVH
`define CODEC_CFG_SVH

// --------------------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------------------
`define REG_CTRL          8'h00
`define REG_MUTE_THR      8'h04
`define REG_RX_DATA       8'h08
`define REG_STATUS        8'h0C

// --------------------------------------------------------------------------
// Control fields and reset values
// --------------------------------------------------------------------------
`define CTRL_LINEAR_BIT   0
`define CTRL_VARRATE_BIT  1
`define CTRL_DCCANCEL_BIT 2
`define CTRL_RESET        3'h0
`define MUTE_THR_RESET    13'h0010
`define MUTE_HYST         13'h0008
`define STAT_OFFSET_LSB   16

// --------------------------------------------------------------------------
// Word lengths and offset averager
// --------------------------------------------------------------------------
`define COMP_BITS         5'd8
`define LIN_WORD_BITS     5'd16
`define DC_ACC_MAX        20'h7FFFF
`define DC_ACC_MIN        20'h80000
`define DC_FRAC           7

`endif

// *** shared/codec_pkg.sv ***
// Types shared by the voice codec serial block.
// Assumes codec_cfg.svh is on the include path.
package codec_pkg;

  typedef enum logic {LAW_MU, LAW_A} law_e;
  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_e;
  typedef enum logic {RX_IDLE, RX_CAPTURE} rx_state_e;
  typedef logic signed [12:0] sample_t;
  typedef logic [15:0] word_t;

endpackage : codec_pkg

// *** shared/cross_if.sv ***
// Carrier for one toggle-to-pulse clock domain crossing.
// The source toggles once per event; the synchroniser returns a one-cycle pulse.
`timescale 1ns/10ps
interface cross_if;
  logic srcToggle;
  logic dstPulse;
  modport src  (output srcToggle);
  modport sync (input srcToggle, output dstPulse);
  modport dst  (input dstPulse);
endinterface : cross_if

// *** rtl/toggle_sync.sv ***
// Two-flop toggle synchroniser with edge detection in the destination domain.
// Assumes the source holds each toggle level for at least three destination cycles.
`timescale 1ns/10ps
module toggle_sync (
  // Destination clock and synchronous reset
  input wire logic dstClk,
  input wire logic dstRst_n,
  // Crossing
  cross_if.sync    xing
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge dstClk) begin
    if (!dstRst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= xing.srcToggle;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign xing.dstPulse = sync_q ^ prev_q;

endmodule : toggle_sync

// *** rtl/voice_codec_serial.sv ***
// Digital serial side of a voice-band codec: sample word framing, companding, attenuation, mute.
// Assumes an APB master on mclk, and a serial partner whose frame syncs and data are synchronous
// to dataClock, which clocks both directions (rising edge transmit, falling edge receive).
`timescale 1ns/10ps
`include "codec_cfg.svh"
module voice_codec_serial
  import codec_pkg::*;
#(
  parameter law_e LAW = LAW_MU
) (
  // System clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Converter side
  input  wire logic [12:0] adcSample,
  input  wire logic        adcValid,
  output logic      [12:0] dacSample,
  output logic             dacValid,
  input  wire logic        transmitSilenceInput,
  // Serial link
  input  wire logic        dataClock,
  input  wire logic        txFrameSync,
  input  wire logic        rxFrameSync,
  input  wire logic        rxData,
  output logic             txData,
  output logic             txDataOe,
  output logic             txSlotStrobe_n
);

  // --------------------------------------------------------------------------
  // Companding and attenuation functions
  // --------------------------------------------------------------------------
  function automatic logic [7:0] compand(input logic [12:0] x);
    logic        neg;
    logic [12:0] mag;
    logic [13:0] biased;
    logic [2:0]  seg;
    logic [3:0]  mant;
    neg    = x[12];
    mag    = neg ? 13'(~x + 13'h0001) : x;
    seg    = 3'h0;
    biased = 14'h0000;
    mant   = 4'h0;
    if (LAW == LAW_A) begin
      if (mag > 13'h0FFF) mag = 13'h0FFF;
      for (int i = 5; i <= 11; i++) if (mag[i]) seg = 3'(i - 4);
      mant = (seg == 3'h0) ? mag[4:1] : 4'(mag >> seg);
      return {~neg, seg, mant} ^ 8'h55;
    end else begin
      biased = {mag, 1'b0};
      if (biased > 14'h1FDE) biased = 14'h1FDE;
      biased = biased + 14'h0021;
      for (int i = 5; i <= 12; i++) if (biased[i]) seg = 3'(i - 5);
      mant = 4'(biased >> ({1'b0, seg} + 4'h1));
      return ~{neg, seg, mant};
    end
  endfunction : compand

  function automatic logic [12:0] expand(input logic [7:0] c);
    logic [7:0]  v;
    logic [12:0] mag;
    logic [15:0] t;
    v   = 8'h00;
    mag = 13'h0000;
    t   = 16'h0000;
    if (LAW == LAW_A) begin
      v = c ^ 8'h55;
      if (v[6:4] == 3'h0) mag = {8'h00, v[3:0], 1'b1};
      else mag = 13'({7'h00, 1'b1, v[3:0], 1'b1} << (v[6:4] - 3'h1));
      return v[7] ? mag : 13'(~mag + 13'h0001);
    end else begin
      v   = ~c;
      t   = 16'({9'h000, v[3:0], 3'h0} + 16'h0084);
      t   = 16'(t << v[6:4]) - 16'h0084;
      mag = t[15:3];
      return v[7] ? 13'(~mag + 13'h0001) : mag;
    end
  endfunction : expand

  // 3 dB per step: halve every two steps, odd steps scale by about 0.69
  function automatic logic [12:0] attenuate(input logic [12:0] x, input logic [2:0] k);
    logic signed [12:0] b;
    b = $signed(x) >>> k[2:1];
    return k[0] ? 13'(b - (b >>> 2) - (b >>> 4)) : b;
  endfunction : attenuate

  // --------------------------------------------------------------------------
  // Register state and APB slave
  // --------------------------------------------------------------------------
  logic [2:0]  ctrl_q;
  logic [12:0] muteThr_q;
  logic [15:0] rxReg_q;
  logic        muted_q;
  logic        silMeta_q;
  logic        silSync_q;
  logic [19:0] dcAcc_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;

  wire        linMode  = ctrl_q[`CTRL_LINEAR_BIT];
  wire        dcEn     = ctrl_q[`CTRL_DCCANCEL_BIT];
  wire [12:0] dcOffset = dcAcc_q[19:`DC_FRAC];
  wire        apbSetup = psel & ~penable & ~pready_q;
  wire        apbWrite = psel & penable & pwrite & pready_q;
  wire        hitCtrl  = paddr == `REG_CTRL;
  wire        hitThr   = paddr == `REG_MUTE_THR;
  wire        hitRx    = paddr == `REG_RX_DATA;
  wire        hitStat  = paddr == `REG_STATUS;
  wire        mapped   = hitCtrl | hitThr | hitRx | hitStat;
  wire [31:0] statWord = {3'h0, dcOffset, 14'h0000, silSync_q, muted_q};
  wire [31:0] rdData   = hitCtrl ? {29'h00000000, ctrl_q} :
                         hitThr  ? {19'h00000, muteThr_q} :
                         hitRx   ? {16'h0000, rxReg_q} :
                         hitStat ? statWord : 32'h00000000;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q <= apbSetup;
      if (apbSetup) begin
        pslverr_q <= ~mapped;
        prdata_q  <= pwrite ? 32'h00000000 : rdData;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctrl_q    <= `CTRL_RESET;
      muteThr_q <= `MUTE_THR_RESET;
    end else if (apbWrite) begin
      if (hitCtrl && pstrb[0]) ctrl_q <= pwdata[2:0];
      if (hitThr && pstrb[0]) muteThr_q[7:0] <= pwdata[7:0];
      if (hitThr && pstrb[1]) muteThr_q[12:8] <= pwdata[12:8];
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // --------------------------------------------------------------------------
  // Transmit encoder path
  // --------------------------------------------------------------------------
  logic [15:0] pendWord_q;
  logic [15:0] holdWord_q;

  cross_if txCross ();
  cross_if rxCross ();

  wire [13:0] corrWide = {adcSample[12], adcSample} - (dcEn ? {dcOffset[12], dcOffset} : 14'h0000);
  wire        corrOvf  = corrWide[13] ^ corrWide[12];
  wire [12:0] corr     = corrOvf ? (corrWide[13] ? 13'h1000 : 13'h0FFF) : corrWide[12:0];
  wire [12:0] corrMag  = corr[12] ? 13'(~corr + 13'h0001) : corr;
  wire [13:0] thrHi    = {1'b0, muteThr_q} + {1'b0, `MUTE_HYST};
  wire        muteNext = muted_q ? ({1'b0, corrMag} <= thrHi) : (corrMag < muteThr_q);
  wire        zeroOut  = silSync_q | (~linMode & muteNext);
  wire [15:0] linWord  = {corr, 3'h0};
  wire [15:0] compWord = {compand(corr), 8'h00};
  wire [15:0] encWord  = zeroOut ? 16'h0000 : (linMode ? linWord : compWord);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      silMeta_q <= 1'b0;
      silSync_q <= 1'b0;
    end else begin
      silMeta_q <= transmitSilenceInput;
      silSync_q <= silMeta_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      muted_q    <= 1'b0;
      dcAcc_q    <= 20'h00000;
      pendWord_q <= 16'h0000;
    end else if (adcValid) begin
      muted_q    <= muteNext;
      pendWord_q <= encWord;
      if (dcEn && !corr[12] && dcAcc_q != `DC_ACC_MAX) dcAcc_q <= dcAcc_q + 20'h00001;
      if (dcEn && corr[12] && dcAcc_q != `DC_ACC_MIN) dcAcc_q <= dcAcc_q - 20'h00001;
    end
  end

  // New word taken only after the link has latched the previous one
  always_ff @(posedge mclk) begin
    if (!reset_n) holdWord_q <= 16'h0000;
    else if (txCross.dstPulse) holdWord_q <= pendWord_q;
  end

  // --------------------------------------------------------------------------
  // Receive decoder path
  // --------------------------------------------------------------------------
  logic [15:0] rxWord_q;
  logic [12:0] dacSample_q;
  logic        dacValid_q;

  wire [12:0] rxSample = linMode ? rxWord_q[15:3] : expand(rxWord_q[15:8]);
  wire [2:0]  rxAtten  = linMode ? rxWord_q[2:0] : 3'h0;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      dacSample_q <= 13'h0000;
      dacValid_q  <= 1'b0;
      rxReg_q     <= 16'h0000;
    end else begin
      dacValid_q <= rxCross.dstPulse;
      if (rxCross.dstPulse) begin
        dacSample_q <= attenuate(rxSample, rxAtten);
        rxReg_q     <= {rxAtten, rxSample};
      end
    end
  end

  assign dacSample = dacSample_q;
  assign dacValid  = dacValid_q;

  // --------------------------------------------------------------------------
  // Link domain reset and mode crossing
  // --------------------------------------------------------------------------
  logic       linkRstMeta_q;
  logic       linkRst_n;
  logic [1:0] modeMeta_q;
  logic [1:0] modeSync_q;

  always_ff @(posedge dataClock) begin
    linkRstMeta_q <= reset_n;
    linkRst_n     <= linkRstMeta_q;
    modeMeta_q    <= {ctrl_q[`CTRL_VARRATE_BIT], ctrl_q[`CTRL_LINEAR_BIT]};
    modeSync_q    <= modeMeta_q;
  end

  wire       linL    = modeSync_q[0];
  wire       varL    = modeSync_q[1];
  wire [4:0] wordLen = linL ? `LIN_WORD_BITS : `COMP_BITS;

  // --------------------------------------------------------------------------
  // Link transmit shifter
  // --------------------------------------------------------------------------
  tx_state_e   txState_q;
  logic        txFsPrev_q;
  logic        txTgl_q;
  logic [15:0] txLatch_q;
  logic [15:0] txShift_q;
  logic [4:0]  txCnt_q;
  logic        txData_q;
  logic        txOe_q;
  logic        txStrobe_n_q;

  wire txRise = txFrameSync & ~txFsPrev_q;

  always_ff @(posedge dataClock) begin
    if (!linkRst_n) begin
      txState_q    <= TX_IDLE;
      txFsPrev_q   <= 1'b0;
      txTgl_q      <= 1'b0;
      txLatch_q    <= 16'h0000;
      txShift_q    <= 16'h0000;
      txCnt_q      <= 5'd0;
      txData_q     <= 1'b0;
      txOe_q       <= 1'b0;
      txStrobe_n_q <= 1'b1;
    end else begin
      txFsPrev_q <= txFrameSync;
      if (txRise) begin
        // holdWord_q is stable here: it last changed a frame ago
        txLatch_q    <= holdWord_q;
        txShift_q    <= {holdWord_q[14:0], 1'b0};
        txData_q     <= holdWord_q[15];
        txCnt_q      <= 5'd1;
        txOe_q       <= 1'b1;
        txStrobe_n_q <= 1'b0;
        txTgl_q      <= ~txTgl_q;
        txState_q    <= TX_SHIFT;
      end else begin
        unique case (txState_q)
          TX_IDLE: begin
            txOe_q       <= 1'b0;
            txStrobe_n_q <= 1'b1;
          end
          TX_SHIFT: begin
            if (varL && !txFrameSync) begin
              txOe_q       <= 1'b0;
              txStrobe_n_q <= 1'b1;
              txState_q    <= TX_IDLE;
            end else if (txCnt_q != wordLen) begin
              txData_q  <= txShift_q[15];
              txShift_q <= {txShift_q[14:0], 1'b0};
              txCnt_q   <= txCnt_q + 5'd1;
            end else if (varL) begin
              txData_q  <= txLatch_q[15];
              txShift_q <= {txLatch_q[14:0], 1'b0};
              txCnt_q   <= 5'd1;
            end else begin
              txOe_q       <= 1'b0;
              txStrobe_n_q <= 1'b1;
              txState_q    <= TX_IDLE;
            end
          end
        endcase
      end
    end
  end

  assign txCross.srcToggle = txTgl_q;
  assign txData            = txData_q;
  assign txDataOe          = txOe_q;
  assign txSlotStrobe_n    = txStrobe_n_q;

  // --------------------------------------------------------------------------
  // Link receive capture on falling edges
  // --------------------------------------------------------------------------
  rx_state_e   rxState_q;
  logic        rxFsPrev_q;
  logic        rxTgl_q;
  logic [15:0] rxShift_q;
  logic [4:0]  rxCnt_q;

  wire        rxRise    = rxFrameSync & ~rxFsPrev_q;
  wire [15:0] rxNext    = {rxShift_q[14:0], rxData};
  wire [4:0]  rxCntInc  = rxCnt_q + 5'd1;
  wire        lastEight = varL & ~linL;

  always_ff @(negedge dataClock) begin
    if (!linkRst_n) begin
      rxState_q  <= RX_IDLE;
      rxFsPrev_q <= 1'b0;
      rxTgl_q    <= 1'b0;
      rxShift_q  <= 16'h0000;
      rxCnt_q    <= 5'd0;
      rxWord_q   <= 16'h0000;
    end else begin
      rxFsPrev_q <= rxFrameSync;
      unique case (rxState_q)
        RX_IDLE: begin
          if (rxRise) begin
            rxShift_q <= {15'h0000, rxData};
            rxCnt_q   <= 5'd1;
            rxState_q <= RX_CAPTURE;
          end
        end
        RX_CAPTURE: begin
          if (lastEight) begin
            if (rxFrameSync) begin
              rxShift_q <= rxNext;
              rxCnt_q   <= (rxCnt_q == `COMP_BITS) ? rxCnt_q : rxCntInc;
            end else begin
              rxState_q <= RX_IDLE;
              if (rxCnt_q == `COMP_BITS) begin
                rxWord_q <= {rxShift_q[7:0], 8'h00};
                rxTgl_q  <= ~rxTgl_q;
              end
            end
          end else if (varL && !rxFrameSync) begin
            rxState_q <= RX_IDLE;
          end else begin
            rxShift_q <= rxNext;
            rxCnt_q   <= rxCntInc;
            if (rxCntInc == wordLen) begin
              rxWord_q  <= linL ? rxNext : {rxNext[7:0], 8'h00};
              rxTgl_q   <= ~rxTgl_q;
              rxState_q <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign rxCross.srcToggle = rxTgl_q;

  // --------------------------------------------------------------------------
  // Crossings into mclk
  // --------------------------------------------------------------------------
  toggle_sync txSyncInst (
    .dstClk   (mclk),
    .dstRst_n (reset_n),
    .xing     (txCross.sync)
  );

  toggle_sync rxSyncInst (
    .dstClk   (mclk),
    .dstRst_n (reset_n),
    .xing     (rxCross.sync)
  );

endmodule : voice_codec_serial

// *** tb/serial_port_model.sv ***
// Far-side serial port: free-running link clock, frame syncs and receive data.
// Assumes the codec drives tx on rising and samples rx on falling dataClock.
`timescale 1ns/10ps
module serial_port_model (
  // Link outputs
  output logic       dataClock,
  output logic       txFrameSync,
  output logic       rxFrameSync,
  output logic       rxData,
  // From codec
  input  wire logic  txData,
  input  wire logic  txDataOe
);
  initial begin
    dataClock = 1'b0;
    #7;
    forever #32 dataClock = ~dataClock;
  end

  initial begin
    txFrameSync = 1'b0;
    rxFrameSync = 1'b0;
    rxData      = 1'b1;
  end

  // ----------------------------------------------------------------------
  // One frame: len bits each way, then idle to a 143-clock period
  // ----------------------------------------------------------------------
  task automatic frame(input logic [31:0] r, input int len, output logic [31:0] t, output logic oeAll);
    t     = 32'h0;
    oeAll = 1'b1;
    repeat (2) @(posedge dataClock);
    txFrameSync <= 1'b1;
    rxFrameSync <= 1'b1;
    rxData      <= r[31];
    for (int k = 0; k <= len; k++) begin
      @(negedge dataClock);
      if (k > 0) begin
        t     = {t[30:0], txData};
        oeAll = oeAll & txDataOe;
      end
      if (k == len - 1) rxFrameSync <= 1'b0;
      rxData <= (k < len - 1) ? r[30 - k] : ~rxData;
    end
    txFrameSync <= 1'b0;
    repeat (141 - len) @(posedge dataClock);
  endtask : frame
endmodule : serial_port_model

// *** tb/voice_codec_serial_chk.sv ***
// Concurrent checks on the voice codec serial top-level ports.
// Assumes modes change only while the link is idle.
`timescale 1ns/10ps
module voice_codec_serial_chk (
  // System
  input wire logic        mclk,
  input wire logic        reset_n,
  // APB, plus DAC sample valid
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        dacValid,
  // Link
  input wire logic        dataClock,
  input wire logic        txFrameSync,
  input wire logic        txData,
  input wire logic        txDataOe,
  input wire logic        txSlotStrobe_n
);
  logic [1:0] modeQ;
  logic [4:0] oeRunQ;

  always_ff @(posedge mclk) begin
    if (!reset_n) modeQ <= 2'h0;
    else if (psel && penable && pready && pwrite && paddr == 8'h00) modeQ <= pwdata[1:0];
  end

  always_ff @(posedge dataClock) begin
    oeRunQ <= txDataOe ? oeRunQ + 5'h1 : 5'h0;
  end

  sequence apbSetup;
    psel && !penable && !pready;
  endsequence
  sequence badAddr;
    apbSetup ##0 (paddr > 8'h0C);
  endsequence

  chk_apb_answer: assert property (@(posedge mclk) disable iff (!reset_n) apbSetup |=> pready)
    else $error("No access answer after setup");
  chk_apb_single: assert property (@(posedge mclk) disable iff (!reset_n) pready |=> !pready)
    else $error("Ready held too long");
  chk_bad_addr: assert property (@(posedge mclk) disable iff (!reset_n) badAddr |=> pready && pslverr && prdata == 32'h0)
    else $error("Unmapped access not refused");
  chk_dac_pulse: assert property (@(posedge mclk) disable iff (!reset_n) dacValid |=> !dacValid)
    else $error("Sample valid longer than one cycle");
  chk_strobe_oe: assert property (@(posedge dataClock) disable iff (!reset_n) txSlotStrobe_n != txDataOe)
    else $error("Slot strobe not inverse of enable");
  chk_tx_start: assert property (@(posedge dataClock) disable iff (!reset_n) $rose(txFrameSync) |=> txDataOe)
    else $error("Transmit did not start at sync");
  chk_word_len: assert property (@(posedge dataClock) disable iff (!reset_n)
    $fell(txDataOe) && !modeQ[1] |-> oeRunQ == (modeQ[0] ? 5'd16 : 5'd8))
    else $error("Fixed-rate word length wrong");
  chk_var_stop: assert property (@(posedge dataClock) disable iff (!reset_n) modeQ[1] && !txFrameSync |=> !txDataOe)
    else $error("Variable-rate output past sync");
  chk_pad_zero: assert property (@(posedge dataClock) disable iff (!reset_n)
    modeQ[0] && txDataOe && oeRunQ[3:0] >= 4'd13 |-> !txData)
    else $error("Linear pad bit not zero");
endmodule : voice_codec_serial_chk

bind voice_codec_serial voice_codec_serial_chk chk_u (
  .mclk(mclk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dacValid(dacValid),
  .dataClock(dataClock), .txFrameSync(txFrameSync), .txData(txData), .txDataOe(txDataOe),
  .txSlotStrobe_n(txSlotStrobe_n)
);

// *** tb/voice_codec_serial_test.sv ***
// Self-checking bench for the voice codec serial block.
// Assumes serial_port_model drives the link; the checker is bound on its own.
`timescale 1ns/10ps
module voice_codec_serial_test;
  logic        mclk, reset_n, psel, penable, pwrite, adcValid, transmitSilenceInput, e, oe, p;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, t;
  logic [12:0] adcSample, dacSample, lastDac;
  logic        pready, pslverr, dacValid, dataClock, txFrameSync, rxFrameSync;
  logic        rxData, txData, txDataOe, txSlotStrobe_n;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          dacCount = 0;
  int          c;
  // Receive level for a -2048 sample at each attenuation step, index = attenuation bits
  localparam logic [7:0][12:0] ATT_STEP = {13'h1F50, 13'h1F00, 13'h1EA0, 13'h1E00,
                                           13'h1D40, 13'h1C00, 13'h1A80, 13'h1800};

  voice_codec_serial dut_u (
    .mclk(mclk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adcSample(adcSample), .adcValid(adcValid), .dacSample(dacSample), .dacValid(dacValid),
    .transmitSilenceInput(transmitSilenceInput), .dataClock(dataClock), .txFrameSync(txFrameSync),
    .rxFrameSync(rxFrameSync), .rxData(rxData), .txData(txData), .txDataOe(txDataOe),
    .txSlotStrobe_n(txSlotStrobe_n)
  );
  serial_port_model far_u (
    .dataClock(dataClock), .txFrameSync(txFrameSync), .rxFrameSync(rxFrameSync), .rxData(rxData),
    .txData(txData), .txDataOe(txDataOe)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (dacValid === 1'b1) begin
      dacCount++;
      lastDac = dacSample;
    end
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic put(input logic [12:0] s);
    @(posedge mclk);
    adcSample <= s;
    adcValid  <= 1'b1;
    @(posedge mclk);
    adcValid  <= 1'b0;
  endtask : put

  task automatic frm(input logic [31:0] r, input int len);
    far_u.frame(r, len, t, oe);
  endtask : frm

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_regs();
    apb(1'b0, 8'h00, 32'h0); check(q, 32'h0);
    apb(1'b0, 8'h04, 32'h0); check(q, 32'h10);
    apb(1'b1, 8'h04, 32'h0ABC);
    apb(1'b0, 8'h04, 32'h0); check(q, 32'h0ABC);
    apb(1'b1, 8'h04, 32'h10);
    apb(1'b0, 8'h40, 32'h0); check({q[30:0], e}, 32'h1);
    apb(1'b1, 8'h00, 32'h4);
    repeat (128) put(13'h0100);
    apb(1'b0, 8'h0C, 32'h0); check(q, 32'h10000);
  endtask : test_regs

  task automatic test_lin_tx();
    apb(1'b1, 8'h00, 32'h1);
    put(13'h1234);
    frm(32'h0, 16);
    frm(32'h0, 16);
    check(t, {16'h0, 13'h1234, 3'h0});
    check(oe, 1'b1);
    @(posedge mclk);
    transmitSilenceInput <= 1'b1;
    repeat (2) @(posedge mclk);
    put(13'h1234);
    apb(1'b0, 8'h0C, 32'h0); check(q, 32'h10002);
    frm(32'h0, 16);
    frm(32'h0, 16);
    check(t, 32'h0);
    @(posedge mclk);
    transmitSilenceInput <= 1'b0;
  endtask : test_lin_tx

  task automatic test_lin_rx();
    for (int k = 0; k < 8; k++) begin
      c = dacCount;
      frm({13'h1800, k[2:0], 16'h0}, 16);
      check(dacCount - c, 32'h1);
      check(lastDac, ATT_STEP[k]);
    end
    apb(1'b0, 8'h08, 32'h0); check(q, {16'h0, 3'h7, 13'h1800});
  endtask : test_lin_rx

  task automatic test_var();
    apb(1'b1, 8'h00, 32'h3);
    put(13'h0ABC);
    frm(32'h0, 32);
    frm(32'h0, 32);
    check(t, {2{13'h0ABC, 3'h0}});
    apb(1'b1, 8'h00, 32'h2);
    c = dacCount;
    frm({4'h5, 8'hC3, 20'h0}, 12);
    check(dacCount - c, 32'h1);
    apb(1'b0, 8'h08, 32'h0); check(q, 32'hD3);
    apb(1'b1, 8'h00, 32'h0);
    frm({8'hC3, 24'h0}, 8);
    apb(1'b0, 8'h08, 32'h0); check(q, 32'hD3);
  endtask : test_var

  task automatic test_comp();
    put(13'h0FFF);
    frm(32'h0, 8);
    frm(32'h0, 8);
    p = t[7];
    put(13'h1000);
    frm(32'h0, 8);
    frm(32'h0, 8);
    check(p ^ t[7], 32'h1);
    check(oe, 1'b1);
    put(13'h0005);
    frm(32'h0, 8);
    frm(32'h0, 8);
    check(t, 32'h0);
  endtask : test_comp

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    adcValid = 1'b0; adcSample = 13'h0; transmitSilenceInput = 1'b0;
    reset_n = 1'b0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    test_regs();
    test_lin_tx();
    test_lin_rx();
    test_var();
    test_comp();
    final_report();
  end

  initial begin
    #1000000;
    bad_count++;
    final_report();
  end
endmodule : voice_codec_serial_test
